// ==== tb/fwcs_peer.sv ====
// serial peer model: answers the port as slave or drives frames as master
`default_nettype none
module fwcs_peer (
    input  wire logic       sys_clk,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic            sck_drv,
    output logic            cs_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cap;
    logic [2:0]  idx;
    logic        miso_r;
    logic        alt;
    logic        mosi_q;
    logic        cs_q;
    int          rises;
    int          cs_rises;
    initial begin
        {cap, idx, miso_r, alt, mosi_q, cs_q} = 23'h000001;
        rises = 0;
        cs_rises = 0;
        sck_drv = 1'b1;
        cs_drv = 1'b1;
    end
    always @(posedge sys_clk) alt <= ~alt;
    // data and select taken where settled: they may move on the very edge that raises the clock
    always @(negedge sys_clk) begin
        mosi_q <= mosi;
        cs_q <= cs_n;
    end
    // deselected data line wanders so a stale bit can never pass
    assign miso = cs_n ? alt : miso_r;
    always @(negedge cs_n) begin
        idx <= 3'h0;
        rises <= 0;
    end
    always @(posedge cs_n) cs_rises <= cs_rises + 1;
    always @(negedge sck) if (!cs_n) begin
        miso_r <= reply[3'h7 - idx];
        idx <= idx + 3'h1;
    end
    always @(posedge sck) if (!cs_q) begin
        cap <= {cap[14:0], mosi_q};
        rises <= rises + 1;
    end
    task automatic hold_cs(input logic v);
        cs_drv = v;
    endtask
    // odd offset keeps the link clock out of phase with sys_clk
    task automatic send_frame();
        #7;
        cs_drv = 1'b0;
        #200;
        repeat (8) begin
            sck_drv = 1'b0;
            #200;
            sck_drv = 1'b1;
            #200;
        end
        cs_drv = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== tb/fwcs_port_tb.sv ====
// self-checking bench for the four-wire chip-select serial port
`default_nettype none
module fwcs_port_tb import fwcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk, resetn, transmit_enable, receive_enable, rx_stop_after_byte, clock_phase_select;
    logic       four_wire_select, cs_output_select, master_select_wr, master_select_wdata, tx_irq_enable;
    logic       tx_end_irq_enable, rx_irq_enable, tx_wr, rx_rd, overrun_clr, conflict_clr, serial_in_pin;
    fwcs_byte_t tx_wdata, rx_data, reply;
    logic       tx_empty_flag, tx_end_flag, rx_full_flag, overrun_flag, conflict_flag, master_select;
    logic       tx_empty_irq, tx_end_irq, rx_full_irq, overrun_irq, serial_clock_pin_out, serial_clock_pin_oe;
    logic       serial_out_pin_out, serial_out_pin_oe, chip_select_pin_out, chip_select_pin_oe;
    logic       sck_drv, cs_drv, sck_line, cs_line, so_line, alt;
    int         bad_count, checks, n, r0;

    assign sck_line = serial_clock_pin_oe ? serial_clock_pin_out : sck_drv;
    // select is pulled up; either party may pull it low
    assign cs_line = (chip_select_pin_oe ? chip_select_pin_out : 1'b1) & cs_drv;
    assign so_line = serial_out_pin_oe ? serial_out_pin_out : alt;

    fwcs_port #(.HALF_DIV(8'h04)) dut_u (.*, .serial_clock_pin_in(sck_line), .chip_select_pin_in(cs_line));
    fwcs_peer peer_u (.sys_clk(sys_clk), .sck(sck_line), .cs_n(cs_line), .mosi(so_line), .reply(reply),
                      .miso(serial_in_pin), .sck_drv(sck_drv), .cs_drv(cs_drv));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) alt <= ~alt;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // 0 read, 1 overrun clear, 2 conflict clear, 3 select write, 4 tx write
    task automatic strobe(input int k);
        @(negedge sys_clk);
        rx_rd = (k == 0);
        overrun_clr = (k == 1);
        conflict_clr = (k == 2);
        master_select_wr = (k == 3);
        tx_wr = (k == 4);
        @(negedge sys_clk);
        {rx_rd, overrun_clr, conflict_clr, master_select_wr, tx_wr} = 5'h00;
    endtask
    function automatic logic flag(input int k);
        case (k)
            0: return tx_end_flag;
            1: return rx_full_flag;
            2: return overrun_flag;
            default: return conflict_flag;
        endcase
    endfunction
    // bounded; the compare that follows catches a miss
    task automatic wait_flag(input int k);
        n = 0;
        while (flag(k) !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task automatic summarize();
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #2000000;
        bad_count++;
        summarize();
    end

    initial begin
        {transmit_enable, receive_enable, rx_stop_after_byte, clock_phase_select, four_wire_select} = 5'h00;
        {cs_output_select, master_select_wr, master_select_wdata, tx_irq_enable, tx_end_irq_enable} = 5'h00;
        {rx_irq_enable, tx_wr, rx_rd, overrun_clr, conflict_clr} = 5'h00;
        {tx_wdata, reply} = 16'h0096;
        {resetn, alt} = 2'h0;
        bad_count = 0;
        checks = 0;
        idle(10);
        resetn = 1'b1;
        check({tx_empty_flag, tx_end_flag, rx_full_flag, overrun_flag, conflict_flag, master_select}, 16'h0020);
        {four_wire_select, cs_output_select, tx_irq_enable, tx_end_irq_enable, rx_irq_enable} = 5'h1F;
        master_select_wdata = 1'b1;
        strobe(3);
        check(master_select, 16'h0001);
        transmit_enable = 1'b1;
        tx_wdata = 8'hA5;
        strobe(4);
        r0 = 0;
        repeat (4) begin
            if (tx_empty_flag === 1'b0) r0 = 1;
            @(negedge sys_clk);
        end
        check(16'(r0), 16'h0001);
        check({tx_empty_flag, tx_empty_irq}, 16'h0003);
        r0 = peer_u.cs_rises;
        tx_wdata = 8'h3C;
        strobe(4);
        wait_flag(0);
        check(peer_u.cap, 16'hA53C);
        idle(4);
        check(16'(peer_u.cs_rises - r0), 16'h0001);
        check({sck_line, cs_line, tx_end_irq}, 16'h0007);
        transmit_enable = 1'b0;
        for (int ph = 0; ph < 2; ph++) begin
            clock_phase_select = ph[0];
            receive_enable = 1'b1;
            rx_stop_after_byte = 1'b1;
            strobe(0);
            wait_flag(1);
            check(16'(peer_u.rises), 16'(8 - ph));
            check({rx_full_flag, rx_full_irq}, 16'h0003);
            if (ph == 0) check(rx_data, 16'h0096);
            idle(100);
            check(16'(peer_u.rises), 16'h0008);
            receive_enable = 1'b0;
            rx_stop_after_byte = 1'b0;
            strobe(0);
            check(rx_full_flag, 16'h0000);
        end
        clock_phase_select = 1'b0;
        receive_enable = 1'b1;
        strobe(0);
        wait_flag(2);
        check({overrun_flag, overrun_irq, rx_full_flag}, 16'h0007);
        idle(40);
        r0 = peer_u.rises;
        idle(40);
        check(16'(peer_u.rises - r0), 16'h0000);
        receive_enable = 1'b0;
        transmit_enable = 1'b1;
        tx_wdata = 8'h81;
        strobe(4);
        idle(40);
        check(tx_empty_flag, 16'h0000);
        strobe(1);
        wait_flag(0);
        check({overrun_flag, rx_full_flag, peer_u.cap[7:0]}, 16'h0181);
        strobe(0);
        check(rx_full_flag, 16'h0000);
        peer_u.hold_cs(1'b0);
        idle(6);
        check({conflict_flag, master_select}, 16'h0002);
        peer_u.hold_cs(1'b1);
        tx_wdata = 8'h5A;
        strobe(4);
        idle(80);
        check(tx_empty_flag, 16'h0000);
        strobe(2);
        check(conflict_flag, 16'h0000);
        cs_output_select = 1'b0;
        receive_enable = 1'b1;
        reply = 8'hC3;
        idle(4);
        check(serial_out_pin_oe, 16'h0000);
        peer_u.send_frame();
        idle(8);
        check({peer_u.cap[7:0], rx_data}, 16'h5AC3);
        check(rx_full_flag, 16'h0001);
        summarize();
    end
endmodule
`default_nettype wire

// ==== verilog/fwcs_defs.svh ====
// constants of the four-wire chip-select serial port
//
// Summary of operation
// - As master, the port drives serial clock and output data itself.
// - As slave, data shifts on the outside clock only while chip select is low.
// - Holding write with transmit enabled clears tx_empty_flag; byte moves to shift register.
// - Byte reaching shift register sets tx_empty_flag; shifting starts; empty interrupt if enabled.
// - Held byte at frame end loads at once; next frame follows gapless.
// - Eighth bit sent with holding empty sets and holds tx_end_flag; interrupt if enabled.
// - After transmit end serial clock stays high; master drives chip select high.
// - No transmission while overrun_flag is set; software clears it first.
// - Master data out floats with chip select; slave input ignored while select high.
// - Master receive and clocking start on a dummy receive data read.
// - Eight bits received store the byte and set rx_full_flag; interrupt if enabled.
// - Reading receive data clears rx_full_flag.
// - With rx_stop_after_byte set, master clocks exactly one byte then stops.
// - Receive data read with receive_enable set restarts master receive clocks.
// - Eighth clock with rx_full_flag set sets overrun_flag and halts until cleared.
// - With clock_phase_select high the receive flags set before the frame ends.
// - Synchronised chip select low during arbitration sets conflict_flag, clears master_select.
// - No transmission while conflict_flag is set; software clears it first.
// - Four-wire bytes always shift most significant bit first.
`ifndef FWCS_DEFS_SVH
`define FWCS_DEFS_SVH

`define FWCS_EDGE_LAST      5'h10
`define FWCS_EDGE_LAST_ODD  5'h0F
`define FWCS_EDGE_FIRST     5'h01
`define FWCS_HALF_DIV       8'h04
`define FWCS_TX_EMPTY_RST   1'b1
`define FWCS_MS_RST         1'b0
`define FWCS_BYTE_RST       8'h00
`define FWCS_SYNC_RST       1'b1

`endif

// ==== verilog/fwcs_pkg.sv ====
// types shared by the four-wire chip-select serial port
`default_nettype none
package fwcs_pkg;
    typedef enum logic [1:0] {
        FWCS_IDLE = 2'b01,
        FWCS_RUN  = 2'b10
    } fwcs_state_e;
    typedef logic [7:0] fwcs_byte_t;
    typedef logic [4:0] fwcs_edge_t;
endpackage
`default_nettype wire

// ==== verilog/fwcs_port.sv ====
// four-wire chip-select serial port: transfer engine, flags and pins
`default_nettype none
`include "fwcs_defs.svh"
module fwcs_port
    import fwcs_pkg::*;
#(
    parameter logic [7:0] HALF_DIV = `FWCS_HALF_DIV
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       transmit_enable,
    input  wire logic       receive_enable,
    input  wire logic       rx_stop_after_byte,
    input  wire logic       clock_phase_select,
    input  wire logic       four_wire_select,
    input  wire logic       cs_output_select,
    input  wire logic       master_select_wr,
    input  wire logic       master_select_wdata,
    input  wire logic       tx_irq_enable,
    input  wire logic       tx_end_irq_enable,
    input  wire logic       rx_irq_enable,
    input  wire logic       tx_wr,
    input  wire logic [7:0] tx_wdata,
    input  wire logic       rx_rd,
    input  wire logic       overrun_clr,
    input  wire logic       conflict_clr,
    output logic      [7:0] rx_data,
    output logic            tx_empty_flag,
    output logic            tx_end_flag,
    output logic            rx_full_flag,
    output logic            overrun_flag,
    output logic            conflict_flag,
    output logic            master_select,
    output logic            tx_empty_irq,
    output logic            tx_end_irq,
    output logic            rx_full_irq,
    output logic            overrun_irq,
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin_out,
    output logic            serial_out_pin_oe,
    input  wire logic       chip_select_pin_in,
    output logic            chip_select_pin_out,
    output logic            chip_select_pin_oe
);
    fwcs_state_e state_r, state_nxt;
    logic [7:0]  div_r, div_nxt;
    fwcs_edge_t  cnt_r, cnt_nxt;
    logic        sck_r, sck_nxt;
    logic        cs_n_r, cs_n_nxt;
    logic        sck_d_r;
    fwcs_byte_t  hold_r, hold_nxt;
    fwcs_byte_t  txs_r, txs_nxt;
    fwcs_byte_t  rxs_r, rxs_nxt;
    fwcs_byte_t  rxd_r, rxd_nxt;
    logic        empty_r, empty_nxt;
    logic        tx_end_flag_r, tx_end_flag_nxt;
    logic        full_r, full_nxt;
    logic        ovr_r, ovr_nxt;
    logic        ce_r, ce_nxt;
    logic        ms_r, ms_nxt;
    logic        go_r, go_nxt;
    logic [1:0]  cs_hist_r, cs_hist_nxt;
    logic        sck_s, sin_s, cs_s;
    logic        can_tx, arb_on, cs_ok, edge_ev, start, arb_quiet;
    logic        tx_load, rx_store, ovr_ev, arb_fail, frame_end, last_samp;

    fwcs_sync #(
        .W(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn (resetn),
        .din    ({serial_clock_pin_in, serial_in_pin, chip_select_pin_in}),
        .dout   ({sck_s, sin_s, cs_s})
    );

    // sample edges: odd ones with phase high, even ones otherwise
    function automatic logic is_samp(input fwcs_edge_t n, input logic ph);
        is_samp = ph ? n[0] : !n[0];
    endfunction

    function automatic logic is_last(input fwcs_edge_t n, input logic ph);
        is_last = ph ? (n == `FWCS_EDGE_LAST_ODD) : (n == `FWCS_EDGE_LAST);
    endfunction

    assign can_tx = transmit_enable && !empty_r && !ovr_r && !ce_r;
    assign arb_on = four_wire_select && cs_output_select && ms_r;
    assign cs_ok  = !four_wire_select || !cs_s;
    // own select still low in the synchroniser after a frame must not read as a conflict
    assign cs_hist_nxt = {cs_hist_r[0], cs_n_r};
    assign arb_quiet   = cs_n_r && (&cs_hist_r);

    always_comb begin
        state_nxt = state_r;
        div_nxt   = div_r;
        cnt_nxt   = cnt_r;
        sck_nxt   = sck_r;
        hold_nxt  = hold_r;
        txs_nxt   = txs_r;
        rxs_nxt   = rxs_r;
        rxd_nxt   = rxd_r;
        empty_nxt = empty_r;
        tx_end_flag_nxt  = tx_end_flag_r;
        full_nxt  = full_r;
        ovr_nxt   = ovr_r;
        ce_nxt    = ce_r;
        ms_nxt    = ms_r;
        go_nxt    = go_r;
        start     = 1'b0;
        edge_ev   = 1'b0;
        tx_load   = 1'b0;
        rx_store  = 1'b0;
        ovr_ev    = 1'b0;
        arb_fail  = 1'b0;
        frame_end = 1'b0;
        last_samp = 1'b0;
        unique case (state_r)
            FWCS_IDLE: begin
                sck_nxt = 1'b1;
                cnt_nxt = '0;
                div_nxt = HALF_DIV - 8'h01;
                if (ms_r) begin
                    if (arb_on && arb_quiet && !cs_s) begin
                        arb_fail = 1'b1;
                    end else if (can_tx || (!transmit_enable && receive_enable && go_r && !ovr_r)) begin
                        start = 1'b1;
                    end
                end else if ((can_tx || (receive_enable && !ovr_r)) && cs_ok) begin
                    start = 1'b1;
                end
                if (start) begin
                    state_nxt = FWCS_RUN;
                    tx_load   = can_tx;
                    go_nxt    = 1'b0;
                end
            end
            FWCS_RUN: begin
                if (!transmit_enable && !receive_enable) begin
                    state_nxt = FWCS_IDLE;
                end else if (ms_r) begin
                    // master makes its own clock from the divider
                    if (div_r == 8'h00) begin
                        div_nxt = HALF_DIV - 8'h01;
                        sck_nxt = !sck_r;
                        edge_ev = 1'b1;
                    end else begin
                        div_nxt = div_r - 8'h01;
                    end
                end else if (!cs_ok) begin
                    state_nxt = FWCS_IDLE;
                end else begin
                    edge_ev = sck_s != sck_d_r;
                end
                if (edge_ev) begin
                    cnt_nxt = cnt_r + `FWCS_EDGE_FIRST;
                    if (is_samp(cnt_nxt, clock_phase_select)) begin
                        rxs_nxt   = {rxs_r[6:0], sin_s};
                        last_samp = is_last(cnt_nxt, clock_phase_select);
                    end else if (cnt_nxt != `FWCS_EDGE_FIRST && cnt_nxt != `FWCS_EDGE_LAST) begin
                        txs_nxt = {txs_r[6:0], 1'b0};
                    end
                    if (last_samp && receive_enable) begin
                        if (full_r) begin
                            ovr_ev    = 1'b1;
                            state_nxt = FWCS_IDLE;
                        end else begin
                            rx_store = 1'b1;
                            rxd_nxt  = rxs_nxt;
                        end
                    end
                    if (cnt_nxt == `FWCS_EDGE_LAST && !ovr_ev) begin
                        frame_end = 1'b1;
                        cnt_nxt   = '0;
                        if (can_tx) begin
                            tx_load = 1'b1;
                        end else if (transmit_enable) begin
                            tx_end_flag_nxt  = 1'b1;
                            state_nxt = FWCS_IDLE;
                        end else if (ms_r && (rx_stop_after_byte || !receive_enable)) begin
                            state_nxt = FWCS_IDLE;
                        end
                    end
                end
            end
        endcase
        if (tx_load) begin
            txs_nxt   = hold_r;
            empty_nxt = 1'b1;
            tx_end_flag_nxt  = 1'b0;
        end
        // a write in the load cycle still leaves the new byte held
        if (tx_wr && transmit_enable) begin
            hold_nxt  = tx_wdata;
            empty_nxt = 1'b0;
            tx_end_flag_nxt  = 1'b0;
        end
        if (rx_rd) begin
            full_nxt = 1'b0;
            go_nxt   = receive_enable;
        end
        if (!receive_enable) begin
            go_nxt = 1'b0;
        end
        if (rx_store) begin
            full_nxt = 1'b1;
        end
        if (overrun_clr) begin
            ovr_nxt = 1'b0;
        end
        if (ovr_ev) begin
            ovr_nxt = 1'b1;
        end
        if (conflict_clr) begin
            ce_nxt = 1'b0;
        end
        if (master_select_wr) begin
            ms_nxt = master_select_wdata;
        end
        if (arb_fail) begin
            ce_nxt = 1'b1;
            ms_nxt = 1'b0;
        end
    end

    assign cs_n_nxt = state_nxt != FWCS_RUN;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= FWCS_IDLE;
            div_r   <= `FWCS_HALF_DIV;
            cnt_r   <= '0;
            sck_r   <= 1'b1;
            cs_n_r  <= 1'b1;
            sck_d_r <= `FWCS_SYNC_RST;
            hold_r  <= `FWCS_BYTE_RST;
            txs_r   <= `FWCS_BYTE_RST;
            rxs_r   <= `FWCS_BYTE_RST;
            rxd_r   <= `FWCS_BYTE_RST;
            empty_r <= `FWCS_TX_EMPTY_RST;
            tx_end_flag_r  <= 1'b0;
            full_r  <= 1'b0;
            ovr_r   <= 1'b0;
            ce_r    <= 1'b0;
            ms_r    <= `FWCS_MS_RST;
            go_r    <= 1'b0;
            cs_hist_r <= {2{`FWCS_SYNC_RST}};
        end else begin
            state_r <= state_nxt;
            div_r   <= div_nxt;
            cnt_r   <= cnt_nxt;
            sck_r   <= sck_nxt;
            cs_n_r  <= cs_n_nxt;
            sck_d_r <= sck_s;
            hold_r  <= hold_nxt;
            txs_r   <= txs_nxt;
            rxs_r   <= rxs_nxt;
            rxd_r   <= rxd_nxt;
            empty_r <= empty_nxt;
            tx_end_flag_r  <= tx_end_flag_nxt;
            full_r  <= full_nxt;
            ovr_r   <= ovr_nxt;
            ce_r    <= ce_nxt;
            ms_r    <= ms_nxt;
            go_r    <= go_nxt;
            cs_hist_r <= cs_hist_nxt;
        end
    end

    assign rx_data       = rxd_r;
    assign tx_empty_flag = empty_r;
    assign tx_end_flag   = tx_end_flag_r;
    assign rx_full_flag  = full_r;
    assign overrun_flag  = ovr_r;
    assign conflict_flag = ce_r;
    assign master_select = ms_r;

    assign tx_empty_irq = empty_r && tx_irq_enable;
    assign tx_end_irq   = tx_end_flag_r && tx_end_irq_enable;
    assign rx_full_irq  = full_r && rx_irq_enable;
    assign overrun_irq  = ovr_r && rx_irq_enable;

    assign serial_clock_pin_out = sck_r;
    assign serial_clock_pin_oe  = ms_r;
    assign chip_select_pin_out  = cs_n_r;
    assign chip_select_pin_oe   = arb_on;
    assign serial_out_pin_out   = txs_r[7];
    // master out floats with the select pin; slave only drives while selected
    assign serial_out_pin_oe = ms_r ? (four_wire_select ? arb_on : transmit_enable)
                                    : (transmit_enable && cs_ok);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_wr_clears_empty;
        (tx_wr && transmit_enable) |=> !tx_empty_flag;
    endproperty
    a_wr_clears_empty: assert property (p_wr_clears_empty) else $error("write did not clear empty");

    property p_load_sets_empty;
        (tx_load && !tx_wr) |=> (tx_empty_flag && txs_r == $past(hold_r));
    endproperty
    a_load_sets_empty: assert property (p_load_sets_empty) else $error("load did not set empty");

    property p_gapless;
        (frame_end && can_tx) |-> (tx_load ##1 state_r == FWCS_RUN);
    endproperty
    a_gapless: assert property (p_gapless) else $error("next frame not started at once");

    sequence s_tx_end_flag_rise;
        !tx_end_flag ##1 tx_end_flag;
    endsequence
    sequence s_tx_end_flag_hold;
        tx_end_flag [*2];
    endsequence
    property p_tx_end_flag;
        (s_tx_end_flag_rise ##0 (!tx_wr && !tx_load)) |-> s_tx_end_flag_hold;
    endproperty
    a_tx_end_flag: assert property (p_tx_end_flag) else $error("end flag not held");

    property p_idle_high;
        (state_r == FWCS_IDLE && ms_r && !start) |=> (serial_clock_pin_out && chip_select_pin_out);
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle master lines not high");

    property p_block_tx;
        (overrun_flag || conflict_flag) |-> !tx_load;
    endproperty
    a_block_tx: assert property (p_block_tx) else $error("load while blocked");

    property p_so_float;
        (ms_r && four_wire_select && !chip_select_pin_oe) |-> !serial_out_pin_oe;
    endproperty
    a_so_float: assert property (p_so_float) else $error("data out driven without select");

    property p_store;
        (rx_store && !rx_rd) |=> (rx_full_flag && rx_data == $past(rxs_nxt));
    endproperty
    a_store: assert property (p_store) else $error("byte not stored");

    property p_rd_clears;
        (rx_rd && !rx_store) |=> !rx_full_flag;
    endproperty
    a_rd_clears: assert property (p_rd_clears) else $error("read did not clear full");

    property p_one_byte;
        (frame_end && ms_r && !transmit_enable && rx_stop_after_byte) |=> (state_r == FWCS_IDLE) [*2];
    endproperty
    a_one_byte: assert property (p_one_byte) else $error("clocking went on past one byte");

    property p_overrun;
        (edge_ev && last_samp && receive_enable && rx_full_flag) |=> (overrun_flag && state_r == FWCS_IDLE);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_conflict;
        (state_r == FWCS_IDLE && arb_on && arb_quiet && !cs_s && !master_select_wr) |=> (conflict_flag && !master_select);
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not taken");
endmodule
`default_nettype wire

// ==== verilog/fwcs_sync.sv ====
// two-flop synchroniser for the serial pins
`default_nettype none
`include "fwcs_defs.svh"
module fwcs_sync #(
    parameter int W = 3
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] hold_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= {W{`FWCS_SYNC_RST}};
            hold_r <= {W{`FWCS_SYNC_RST}};
        end else begin
            meta_r <= din;
            hold_r <= meta_r;
        end
    end

    assign dout = hold_r;
endmodule
`default_nettype wire
